// *** src/dsc_pkg.sv ***
// Constants, word layout and helpers for the serial config and LO sync block
package dsc_pkg;
	// Word and field sizes
	localparam int          WORD_W          = 20;
	localparam int          NUM_CH          = 4;
	localparam int          PH_W            = 4;
	// Word layout: channel 0 phase in the top nibble, enables in the bottom nibble
	localparam int          PH_CH0_LSB      = 16;
	localparam int          PH_CH1_LSB      = 12;
	localparam int          PH_CH2_LSB      = 8;
	localparam int          PH_CH3_LSB      = 4;
	localparam int          EN_LSB          = 0;
	// Reset and special values
	localparam logic [19:0] WORD_RESET      = 20'h00000;
	localparam logic [3:0]  EN_NONE         = 4'h0;
	localparam logic [3:0]  EN_ALL          = 4'hF;
	localparam logic [3:0]  PH_QUICK        = 4'h0;
	localparam logic [1:0]  LO_START        = 2'h0;
	localparam logic [1:0]  LO_STEP         = 2'h1;
	// Register byte offsets
	localparam logic [7:0]  OFS_CTRL        = 8'h00;
	localparam logic [7:0]  OFS_STATUS      = 8'h04;
	localparam logic [7:0]  OFS_LATCH       = 8'h08;
	localparam logic [7:0]  OFS_SHIFT       = 8'h0C;
	// Control and status bit positions
	localparam int          CTRL_SOFT_CLEAR = 0;
	localparam int          CTRL_SOFT_HOLD  = 1;
	localparam logic [1:0]  CTRL_RESET      = 2'h0;
	localparam int          STAT_PD         = 0;
	localparam int          STAT_LO_HOLD    = 1;
	localparam int          STAT_LO_CNT_LSB = 2;
	localparam int          STAT_LO_I       = 4;
	localparam int          STAT_LO_Q       = 5;
	// AHB-Lite encodings
	localparam int          HTRANS_ACT_BIT  = 1;
	localparam logic        HRESP_OKAY      = 1'b0;

	// Channel enable nibble of a word
	function automatic logic [3:0] enables(input logic [19:0] word);
		enables = word[EN_LSB +: NUM_CH];
	endfunction : enables

	// Phase code of one channel, MSB first within the nibble
	function automatic logic [3:0] phase(input logic [19:0] word, input logic [1:0] ch);
		unique case (ch)
			2'h0: phase = word[PH_CH0_LSB +: PH_W];
			2'h1: phase = word[PH_CH1_LSB +: PH_W];
			2'h2: phase = word[PH_CH2_LSB +: PH_W];
			2'h3: phase = word[PH_CH3_LSB +: PH_W];
		endcase
	endfunction : phase

	// In-phase LO level for a divider state
	function automatic logic lo_i(input logic [1:0] cnt);
		lo_i = (cnt == 2'h0) || (cnt == 2'h1);
	endfunction : lo_i

	// Quadrature LO level, a quarter cycle behind in-phase
	function automatic logic lo_q(input logic [1:0] cnt);
		lo_q = (cnt == 2'h1) || (cnt == 2'h2);
	endfunction : lo_q
endpackage : dsc_pkg

// *** src/dsc_edge.sv ***
// Edge detector for a synchronous pin level
`timescale 1ns/100ps
`default_nettype none
module dsc_edge (
	input  wire logic i_clock,  // System clock
	input  wire logic i_rst_n,  // Async reset, active low
	input  wire logic i_level,  // Sampled pin level
	output logic      o_rise,   // Rising edge pulse
	output logic      o_fall    // Falling edge pulse
);
	typedef struct packed {
		logic level;
	} dsc_edge_t;

	dsc_edge_t st;
	dsc_edge_t next_st;

	// Remember the previous level
	always_comb begin
		next_st       = st;
		next_st.level = i_level;
	end

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	// Edge pulses from previous and current level
	assign o_rise = i_level & ~st.level;
	assign o_fall = ~i_level & st.level;
endmodule : dsc_edge
`default_nettype wire

// *** src/dsc_lodiv.sv ***
// Divide-by-four LO divider with sync hold and quadrature outputs
`timescale 1ns/100ps
`default_nettype none
module dsc_lodiv (
	input  wire logic       i_clock,   // System clock
	input  wire logic       i_rst_n,   // Async reset, active low
	input  wire logic       i_lo_rise, // Quad rate LO rising edge pulse
	input  wire logic       i_hold,    // Stop and reset the divider
	output logic [1:0]      o_cnt,     // Divider quadrant state
	output logic            o_lo_i,    // In-phase LO
	output logic            o_lo_q     // Quadrature LO
);
	typedef struct packed {
		logic [1:0] cnt;
		logic       lo_i;
		logic       lo_q;
	} dsc_lodiv_t;

	dsc_lodiv_t st;
	dsc_lodiv_t next_st;

	// Advance on LO edges, park at the start state while held
	always_comb begin
		next_st = st;
		if (i_hold) begin
			next_st.cnt = dsc_pkg::LO_START;
		end else if (i_lo_rise) begin
			next_st.cnt = 2'(st.cnt + dsc_pkg::LO_STEP);
		end
		next_st.lo_i = dsc_pkg::lo_i(next_st.cnt);
		next_st.lo_q = dsc_pkg::lo_q(next_st.cnt);
	end

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			st <= '{cnt: dsc_pkg::LO_START, lo_i: 1'b1, lo_q: 1'b0};
		end else begin
			st <= next_st;
		end
	end

	assign o_cnt  = st.cnt;
	assign o_lo_i = st.lo_i;
	assign o_lo_q = st.lo_q;

	// Hold, then released in the same cycle as an LO edge
	sequence s_release_edge;
		i_hold ##1 (!i_hold && i_lo_rise);
	endsequence

	AST_LO_HELD: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		i_hold |=> (st.cnt == dsc_pkg::LO_START) && st.lo_i && !st.lo_q)
		else $error("LO divider not parked while held");

	AST_LO_RESTART: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		s_release_edge |=> (st.cnt == 2'h1))
		else $error("LO divider did not restart on first edge");

	AST_LO_QUAD: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		(!i_hold && i_lo_rise) |=> (($past(st.lo_i) != st.lo_i) != ($past(st.lo_q) != st.lo_q)))
		else $error("I and Q not a quarter cycle apart");
endmodule : dsc_lodiv
`default_nettype wire

// *** src/dsc_top.sv ***
// Serial configuration port, latch decode and LO sync of the quad demodulator
//
// Our own choices: the register offsets and the AHB-Lite register port.
`timescale 1ns/100ps
`default_nettype none
module dsc_top (
	input  wire logic        I_CLOCK,                 // System clock, 25 MHz
	input  wire logic        I_RST_N,                 // Async reset, active low
	input  wire logic        I_SERIAL_CLOCK,          // Serial shift clock
	input  wire logic        I_SERIAL_DATA_INPUT,     // Serial data in
	input  wire logic        I_SELECT_LATCH_STROBE_N, // Select, rising edge latches
	input  wire logic        I_SERIAL_CLEAR_PIN,      // Serial clear, active high
	input  wire logic        I_QUICK_TEST_NEG,        // Clear pin driven negative
	input  wire logic        I_LO_SYNC_PULSE,         // LO sync reset, active high
	input  wire logic        I_QUAD_RATE_LO_CLOCK,    // Four times LO clock level
	output logic             O_SERIAL_DATA_OUTPUT,    // Serial data out, daisy chain
	output logic [3:0]       O_CHANNEL_ENABLE_BITS,   // Per channel enables
	output logic [3:0]       O_PHASE_CH0,             // Channel 0 phase code
	output logic [3:0]       O_PHASE_CH1,             // Channel 1 phase code
	output logic [3:0]       O_PHASE_CH2,             // Channel 2 phase code
	output logic [3:0]       O_PHASE_CH3,             // Channel 3 phase code
	output logic             O_POWER_DOWN,            // Core powered down
	output logic             O_LO_I,                  // In-phase LO
	output logic             O_LO_Q,                  // Quadrature LO
	output logic [1:0]       O_LO_QUADRANT,           // Divider state
	input  wire logic        I_HSEL,                  // AHB slave select
	input  wire logic [31:0] I_HADDR,                 // AHB address
	input  wire logic [1:0]  I_HTRANS,                // AHB transfer type
	input  wire logic        I_HWRITE,                // AHB write
	input  wire logic [2:0]  I_HSIZE,                 // AHB size, word only
	input  wire logic [31:0] I_HWDATA,                // AHB write data
	input  wire logic        I_HREADY,                // AHB bus ready
	output logic [31:0]      O_HRDATA,                // AHB read data
	output logic             O_HREADYOUT,             // AHB slave ready
	output logic             O_HRESP                  // AHB response
);
	typedef struct packed {
		logic [19:0] shift;
		logic [19:0] latch;
		logic        pd;
		logic [1:0]  ctrl;
		logic        wr_ctrl;
		logic [31:0] rdata;
	} dsc_core_t;

	dsc_core_t   st;
	dsc_core_t   next_st;

	logic        sclk_rise;
	logic        strobe_rise;
	logic        clr_pin_fall;
	logic        lo_rise;
	logic        clr;
	logic        lo_hold;
	logic        accept;
	logic [1:0]  lo_cnt;
	logic        lo_i;
	logic        lo_q;
	logic [19:0] quick_word;

	// Serial clock edge
	dsc_edge u_sclk_edge (
		.i_clock (I_CLOCK),
		.i_rst_n (I_RST_N),
		.i_level (I_SERIAL_CLOCK),
		.o_rise  (sclk_rise),
		.o_fall  ()
	);

	// Select strobe edge, the latch clock
	dsc_edge u_strobe_edge (
		.i_clock (I_CLOCK),
		.i_rst_n (I_RST_N),
		.i_level (I_SELECT_LATCH_STROBE_N),
		.o_rise  (strobe_rise),
		.o_fall  ()
	);

	// Serial clear release, for quick test entry
	dsc_edge u_clear_edge (
		.i_clock (I_CLOCK),
		.i_rst_n (I_RST_N),
		.i_level (I_SERIAL_CLEAR_PIN),
		.o_rise  (),
		.o_fall  (clr_pin_fall)
	);

	// Quad rate LO edge
	dsc_edge u_lo_edge (
		.i_clock (I_CLOCK),
		.i_rst_n (I_RST_N),
		.i_level (I_QUAD_RATE_LO_CLOCK),
		.o_rise  (lo_rise),
		.o_fall  ()
	);

	// Divider stopped by sync pulse, power-down or software hold
	assign lo_hold = I_LO_SYNC_PULSE | st.pd | st.ctrl[dsc_pkg::CTRL_SOFT_HOLD];

	// LO divider
	dsc_lodiv u_lodiv (
		.i_clock   (I_CLOCK),
		.i_rst_n   (I_RST_N),
		.i_lo_rise (lo_rise),
		.i_hold    (lo_hold),
		.o_cnt     (lo_cnt),
		.o_lo_i    (lo_i),
		.o_lo_q    (lo_q)
	);

	// Clear from pin or software
	assign clr    = I_SERIAL_CLEAR_PIN | st.ctrl[dsc_pkg::CTRL_SOFT_CLEAR];
	assign accept = I_HSEL & I_HTRANS[dsc_pkg::HTRANS_ACT_BIT] & I_HREADY;

	assign quick_word = {dsc_pkg::PH_QUICK, dsc_pkg::PH_QUICK, dsc_pkg::PH_QUICK,
		dsc_pkg::PH_QUICK, dsc_pkg::EN_ALL};

	// Address decode; upper bits must be zero
	function automatic logic hit(input logic [31:0] addr, input logic [7:0] ofs);
		hit = (addr[31:8] == 24'h000000) && (addr[7:0] == ofs);
	endfunction : hit

	// Read data for an address, unmapped reads zero
	function automatic logic [31:0] read_mux(input logic [31:0] addr, input dsc_core_t s,
		input logic [5:0] stat_lo);
		logic [31:0] d;
		d = 32'h00000000;
		if (hit(addr, dsc_pkg::OFS_CTRL)) begin
			d[1:0] = s.ctrl;
		end else if (hit(addr, dsc_pkg::OFS_STATUS)) begin
			d[5:0] = stat_lo;
		end else if (hit(addr, dsc_pkg::OFS_LATCH)) begin
			d[19:0] = s.latch;
		end else if (hit(addr, dsc_pkg::OFS_SHIFT)) begin
			d[19:0] = s.shift;
		end
		read_mux = d;
	endfunction : read_mux

	// Next state of port, latch and register slave
	always_comb begin
		logic [5:0] stat_lo;
		stat_lo                            = 6'h00;
		stat_lo[dsc_pkg::STAT_PD]          = st.pd;
		stat_lo[dsc_pkg::STAT_LO_HOLD]     = lo_hold;
		stat_lo[dsc_pkg::STAT_LO_CNT_LSB +: 2] = lo_cnt;
		stat_lo[dsc_pkg::STAT_LO_I]        = lo_i;
		stat_lo[dsc_pkg::STAT_LO_Q]        = lo_q;
		next_st = st;
		// Register slave: write in data phase, read captured in address phase
		next_st.wr_ctrl = accept && I_HWRITE && hit(I_HADDR, dsc_pkg::OFS_CTRL);
		if (accept && !I_HWRITE) begin
			next_st.rdata = read_mux(I_HADDR, st, stat_lo);
		end
		if (st.wr_ctrl) begin
			next_st.ctrl = I_HWDATA[1:0];
		end
		if (clr) begin
			next_st.shift = dsc_pkg::WORD_RESET;
			next_st.latch = dsc_pkg::WORD_RESET;
		end else begin
			if (clr_pin_fall && I_QUICK_TEST_NEG) begin
				next_st.latch = quick_word;
			end
			if (strobe_rise) begin
				next_st.latch = st.shift;
			end
			if (sclk_rise) begin
				next_st.shift = {st.shift[18:0], I_SERIAL_DATA_INPUT};
			end
		end
		next_st.pd = (dsc_pkg::enables(next_st.latch) == dsc_pkg::EN_NONE);
	end

	// State register
	always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			st <= '{shift: dsc_pkg::WORD_RESET, latch: dsc_pkg::WORD_RESET, pd: 1'b1,
				ctrl: dsc_pkg::CTRL_RESET, wr_ctrl: 1'b0, rdata: 32'h00000000};
		end else begin
			st <= next_st;
		end
	end

	assign O_SERIAL_DATA_OUTPUT  = st.shift[19];
	assign O_CHANNEL_ENABLE_BITS = dsc_pkg::enables(st.latch);
	assign O_PHASE_CH0           = dsc_pkg::phase(st.latch, 2'h0);
	assign O_PHASE_CH1           = dsc_pkg::phase(st.latch, 2'h1);
	assign O_PHASE_CH2           = dsc_pkg::phase(st.latch, 2'h2);
	assign O_PHASE_CH3           = dsc_pkg::phase(st.latch, 2'h3);
	assign O_POWER_DOWN          = st.pd;
	assign O_LO_I                = lo_i;
	assign O_LO_Q                = lo_q;
	assign O_LO_QUADRANT         = lo_cnt;

	// Zero wait state slave, always OKAY
	assign O_HRDATA    = st.rdata;
	assign O_HREADYOUT = 1'b1;
	assign O_HRESP     = dsc_pkg::HRESP_OKAY;

	// A clean shift step with no clear
	sequence s_shift_step;
		sclk_rise && !clr;
	endsequence

	// A clean strobe with no clear
	sequence s_strobe;
		strobe_rise && !clr;
	endsequence

	AST_SHIFT_MSB_FIRST: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
		s_shift_step |=> (st.shift[0] == $past(I_SERIAL_DATA_INPUT))
			&& (st.shift[19:1] == $past(st.shift[18:0])))
		else $error("Shift step wrong");

	AST_SHIFT_IDLE: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
		(!sclk_rise && !clr) |=> $stable(st.shift))
		else $error("Shift register moved without clock edge");

	AST_SERIAL_OUT: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
		s_shift_step |=> (O_SERIAL_DATA_OUTPUT == $past(st.shift[18])))
		else $error("Serial output not the shifted end bit");

	AST_LATCH_ON_STROBE: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
		s_strobe |=> (st.latch == $past(st.shift)))
		else $error("Latch did not take shift contents");

	AST_LATCH_HOLDS: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
		(!strobe_rise && !clr && !clr_pin_fall) |=> $stable(st.latch))
		else $error("Latch changed without strobe");

	AST_CLEAR: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
		clr |=> (st.shift == dsc_pkg::WORD_RESET) && (st.latch == dsc_pkg::WORD_RESET)
			&& O_POWER_DOWN)
		else $error("Serial clear did not zero the port");

	AST_QUICK_TEST: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
		(clr_pin_fall && I_QUICK_TEST_NEG && !clr && !strobe_rise)
			|=> (O_CHANNEL_ENABLE_BITS == dsc_pkg::EN_ALL) && (O_PHASE_CH0 == dsc_pkg::PH_QUICK)
			&& (O_PHASE_CH3 == dsc_pkg::PH_QUICK))
		else $error("Quick test did not enable all channels");

	AST_WAKE: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
		(s_strobe ##0 (dsc_pkg::enables(st.shift) != dsc_pkg::EN_NONE)) |=> !O_POWER_DOWN)
		else $error("Wake word did not leave power-down");

	AST_POWER_DOWN: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
		O_POWER_DOWN |-> ((O_CHANNEL_ENABLE_BITS == dsc_pkg::EN_NONE) && lo_hold
			##1 (lo_cnt == dsc_pkg::LO_START)))
		else $error("Power-down not tied to enables and LO");

	AST_SYNC_HOLD: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
		I_LO_SYNC_PULSE[*2] |-> (lo_cnt == dsc_pkg::LO_START) && O_LO_I && !O_LO_Q)
		else $error("Sync pulse did not hold the divider");

	AST_READ_LATCH: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
		(accept && !I_HWRITE && hit(I_HADDR, dsc_pkg::OFS_LATCH))
			|=> (O_HRDATA == {12'h000, $past(st.latch)}))
		else $error("Latch read data wrong");

	// Sync pulse dropped in the same sample as an LO rise
	sequence s_sync_release;
		I_LO_SYNC_PULSE ##1 (!lo_hold && lo_rise);
	endsequence

	// Divider restart after the sync pulse, idle behaviour and software hold
	AST_SYNC_RESTART: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
		s_sync_release |=> (lo_cnt == 2'(dsc_pkg::LO_START + dsc_pkg::LO_STEP)))
		else $error("Divider did not restart after sync release");

	AST_LO_WAITS: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
		(!lo_hold && !lo_rise) |=> $stable(lo_cnt))
		else $error("Divider moved without an LO edge");

	AST_SOFT_HOLD: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
		st.ctrl[dsc_pkg::CTRL_SOFT_HOLD]
			|=> (lo_cnt == dsc_pkg::LO_START) && O_LO_I && !O_LO_Q)
		else $error("Software hold did not park the divider");

	// Power-down flag and decoded fields against the latched word
	AST_PD_MATCHES_EN: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
		O_POWER_DOWN == (O_CHANNEL_ENABLE_BITS == dsc_pkg::EN_NONE))
		else $error("Power-down flag disagrees with enables");

	AST_STROBE_DECODE: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
		s_strobe |=> (O_CHANNEL_ENABLE_BITS == $past(st.shift[dsc_pkg::EN_LSB +: dsc_pkg::NUM_CH]))
			&& (O_PHASE_CH0 == $past(st.shift[dsc_pkg::PH_CH0_LSB +: dsc_pkg::PH_W]))
			&& (O_PHASE_CH3 == $past(st.shift[dsc_pkg::PH_CH3_LSB +: dsc_pkg::PH_W])))
		else $error("Latched fields do not match the strobed word");

	// Serial output and register reads of the port
	AST_SDO_STABLE: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
		(!sclk_rise && !clr) |=> $stable(O_SERIAL_DATA_OUTPUT))
		else $error("Serial output moved without clock edge");

	AST_READ_SHIFT: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
		(accept && !I_HWRITE && hit(I_HADDR, dsc_pkg::OFS_SHIFT))
			|=> (O_HRDATA == {12'h000, $past(st.shift)}))
		else $error("Shift read data wrong");

	AST_STATUS_READ: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
		(accept && !I_HWRITE && hit(I_HADDR, dsc_pkg::OFS_STATUS))
			|=> (O_HRDATA[dsc_pkg::STAT_PD] == $past(st.pd))
			&& (O_HRDATA[dsc_pkg::STAT_LO_CNT_LSB +: 2] == $past(lo_cnt)))
		else $error("Status read data wrong");
endmodule : dsc_top
`default_nettype wire

// *** test/dsc_ctrl_model.sv ***
// Serial controller model that drives the configuration link of the device
`timescale 1ns/100ps
`default_nettype none
module dsc_ctrl_model (
	input  wire logic i_clock,    // System clock
	input  wire logic i_sdo,      // Device serial data output
	output logic      o_sclk,     // Serial clock, idle low between frames
	output logic      o_sdi,      // Serial data to the device
	output logic      o_strobe_n  // Select, rising edge latches
);
	// Idle levels before the first frame
	initial begin
		o_sclk     = 1'b0;
		o_sdi      = 1'b0;
		o_strobe_n = 1'b0;
	end

	// Shift one word and capture what leaves the far end of the device
	task automatic send(input logic [19:0] word, input bit latch, input int slow,
		output logic [19:0] seen);
		for (int i = 19; i >= 0; i--) begin
			@(posedge i_clock);
			o_sclk <= 1'b0;
			o_sdi  <= word[i];
			repeat (slow) @(posedge i_clock);
			@(posedge i_clock);
			o_sclk <= 1'b1;
			seen[i] = i_sdo;
		end
		// Released data line shows the inverse of the last bit
		@(posedge i_clock);
		o_sclk <= 1'b0;
		o_sdi  <= ~word[0];
		if (latch) begin
			@(posedge i_clock);
			o_strobe_n <= 1'b1;
			repeat (2) @(posedge i_clock);
			o_strobe_n <= 1'b0;
		end
	endtask : send
endmodule : dsc_ctrl_model
`default_nettype wire

// *** test/test_demod_serial_config_and_lo_sync.sv ***
// Self-checking bench for the serial config and LO sync block
`timescale 1ns/100ps
`default_nettype none
module test_demod_serial_config_and_lo_sync;
	logic        clk;
	logic        rst_n  = 1'b0;
	logic        clr    = 1'b0;
	logic        qneg   = 1'b0;
	logic        sync   = 1'b0;
	logic        lo     = 1'b0;
	logic        hsel   = 1'b0;
	logic        hwrite = 1'b0;
	logic [1:0]  htrans = 2'h0;
	logic [31:0] haddr  = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic        sclk, serial_data_input, strobe_n, serial_data_output, pd, lo_i, lo_q, hreadyout, hresp;
	logic [1:0]  quad;
	logic [31:0] hrdata, rd;
	logic [3:0]  en, ph0, ph1, ph2, ph3;
	logic [19:0] seen, w;
	int          error_cnt, n_tests, m_shift, m_latch;

	// System clock, 25 MHz
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	dsc_top dut (
		.I_CLOCK(clk), .I_RST_N(rst_n), .I_SERIAL_CLOCK(sclk), .I_SERIAL_DATA_INPUT(serial_data_input),
		.I_SELECT_LATCH_STROBE_N(strobe_n), .I_SERIAL_CLEAR_PIN(clr), .I_QUICK_TEST_NEG(qneg),
		.I_LO_SYNC_PULSE(sync), .I_QUAD_RATE_LO_CLOCK(lo), .O_SERIAL_DATA_OUTPUT(serial_data_output),
		.O_CHANNEL_ENABLE_BITS(en), .O_PHASE_CH0(ph0), .O_PHASE_CH1(ph1), .O_PHASE_CH2(ph2),
		.O_PHASE_CH3(ph3), .O_POWER_DOWN(pd), .O_LO_I(lo_i), .O_LO_Q(lo_q),
		.O_LO_QUADRANT(quad), .I_HSEL(hsel), .I_HADDR(haddr), .I_HTRANS(htrans),
		.I_HWRITE(hwrite), .I_HSIZE(3'h2), .I_HWDATA(hwdata), .I_HREADY(hreadyout),
		.O_HRDATA(hrdata), .O_HREADYOUT(hreadyout), .O_HRESP(hresp)
	);

	dsc_ctrl_model ctrl (
		.i_clock(clk), .i_sdo(serial_data_output), .o_sclk(sclk), .o_sdi(serial_data_input), .o_strobe_n(strobe_n)
	);

	// Verdict and end of run
	task automatic final_report;
		if (error_cnt == 0 && n_tests > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : final_report

	// Compare one value and count it
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		n_tests++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask : chk

	// One single AHB-Lite transfer, waits on the ready handshake
	task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r);
		@(posedge clk);
		hsel   <= 1'b1;
		htrans <= 2'h2;
		haddr  <= {24'h0, a};
		hwrite <= wr;
		do @(posedge clk); while (hreadyout !== 1'b1);
		hsel   <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (hreadyout !== 1'b1);
		r = hrdata;
		chk(32'(hresp), 32'h0, "response");
	endtask : ahb

	// Latched outputs against the model
	task automatic outs;
		chk(32'(en), 32'(m_latch[3:0]), "enables");
		chk(32'({ph0, ph1, ph2, ph3}), 32'(m_latch[19:4]), "phases");
		chk(32'(pd), 32'(m_latch[3:0] == 0), "power down");
		ahb(1'b0, 8'h08, 32'h0, rd);
		chk(rd, m_latch, "latch register");
	endtask : outs

	// One frame through the partner, then shift, output and latch checks
	task automatic frame(input logic [19:0] word, input bit latch);
		ctrl.send(word, latch, $urandom_range(2, 0), seen);
		chk(32'(seen), m_shift, "daisy chain stream");
		m_shift = word;
		if (latch) m_latch = word;
		repeat (3) @(posedge clk);
		ahb(1'b0, 8'h0C, 32'h0, rd);
		chk(rd, m_shift, "shift register");
		chk(32'(serial_data_output), 32'(m_shift[19]), "serial out");
		outs();
	endtask : frame

	// One period of the quad rate LO, each level held two cycles
	task automatic lo_pulse;
		@(posedge clk);
		lo <= 1'b1;
		repeat (2) @(posedge clk);
		lo <= 1'b0;
		repeat (2) @(posedge clk);
	endtask : lo_pulse

	// Main sequence
	initial begin
		error_cnt = 0;
		n_tests   = 0;
		m_shift   = 0;
		m_latch   = 0;
		void'($urandom(32'h144aa417));
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		outs();
		chk(32'({quad, lo_i, lo_q}), 32'h2, "lo after reset");
		// Random words; one left unlatched, one with all enables off, then wake
		for (int k = 0; k < 6; k++) begin
			w = 20'($urandom);
			if (k == 1) w[19:4] = 16'h0246;
			if (k == 3) w[3:0] = 4'h0;
			if (k == 4) w[0] = 1'b1;
			frame(w, k != 2);
			if (k == 4) repeat (375) @(posedge clk);
		end
		// Clear held high: shifting and latching refused, both cleared
		@(posedge clk);
		clr <= 1'b1;
		ctrl.send(20'($urandom), 1'b1, 0, seen);
		clr <= 1'b0;
		m_shift = 0;
		m_latch = 0;
		repeat (3) @(posedge clk);
		outs();
		ahb(1'b0, 8'h0C, 32'h0, rd);
		chk(rd, m_shift, "shift after clear");
		// Quick test: clear high, then driven negative
		@(posedge clk);
		clr <= 1'b1;
		repeat (2) @(posedge clk);
		clr  <= 1'b0;
		qneg <= 1'b1;
		repeat (2) @(posedge clk);
		qneg <= 1'b0;
		m_latch = 32'h0000F;
		repeat (2) @(posedge clk);
		outs();
		// Sync pulse on all channels with equal codes, LO held meanwhile
		// pulse far beyond 20 ns
		@(posedge clk);
		sync <= 1'b1;
		lo_pulse();
		lo_pulse();
		chk(32'(quad), 32'h0, "held divider");
		sync <= 1'b0;
		repeat (3) @(posedge clk);
		chk(32'(quad), 32'h0, "waiting for lo rise");
		for (int i = 1; i < 7; i++) begin
			lo_pulse();
			chk(32'(quad), i % 4, "divider step");
			chk(32'({lo_i, lo_q}), 32'({i % 4 < 2, i % 4 == 1 || i % 4 == 2}), "i q");
		end
		// Status: quadrant two, Q high, I low, running and awake
		ahb(1'b0, 8'h04, 32'h0, rd);
		chk(rd, 32'h28, "status running");
		@(posedge clk);
		sync <= 1'b1;
		// LO rise seen as sync drops
		@(posedge clk);
		sync <= 1'b0;
		lo   <= 1'b1;
		repeat (2) @(posedge clk);
		lo <= 1'b0;
		repeat (2) @(posedge clk);
		chk(32'(quad), 32'h1, "restart after sync");
		// Registers: control readback, read-only and unmapped places, soft clear
		ahb(1'b1, 8'h08, 32'h12345, rd);
		outs();
		ahb(1'b1, 8'h10, 32'hFFFF, rd);
		ahb(1'b0, 8'h10, 32'h0, rd);
		chk(rd, 32'h0, "unmapped read");
		ahb(1'b1, 8'h00, 32'h3, rd);
		// Soft clear and hold: power-down, hold, quadrant zero, I high
		ahb(1'b0, 8'h04, 32'h0, rd);
		chk(rd, 32'h13, "status held and cleared");
		ahb(1'b0, 8'h00, 32'h0, rd);
		chk(rd, 32'h3, "control readback");
		ahb(1'b1, 8'h00, 32'h0, rd);
		m_latch = 0;
		outs();
		final_report();
	end

	// Watchdog well beyond the expected run length
	initial begin
		repeat (20000) @(posedge clk);
		error_cnt++;
		final_report();
	end
endmodule : test_demod_serial_config_and_lo_sync
`default_nettype wire
